// ===== include/r1cfg_pkg.sv
// Constants for the rail 1 configuration page register bank
package r1cfg_pkg;

    // ==============================================================
    // Command codes on the configuration page
    localparam logic [7:0] R1CFG_OFS_PAGE     = 8'h00;
    localparam logic [7:0] R1CFG_OFS_SLEW     = 8'h01;
    localparam logic [7:0] R1CFG_OFS_ICCMAX   = 8'h02;
    localparam logic [7:0] R1CFG_OFS_VIDMODE  = 8'h03;
    localparam logic [7:0] R1CFG_OFS_IOFFSET  = 8'h04;
    localparam logic [7:0] R1CFG_OFS_BUSADDR  = 8'h05;

    // ==============================================================
    // Page selector codes
    localparam int         R1CFG_PAGE_W       = 6;
    localparam logic [5:0] R1CFG_PAGE_OP0     = 6'h00;
    localparam logic [5:0] R1CFG_PAGE_OP1     = 6'h01;
    localparam logic [5:0] R1CFG_PAGE_OP2     = 6'h02;
    localparam logic [5:0] R1CFG_PAGE_NV0     = 6'h28;
    localparam logic [5:0] R1CFG_PAGE_NV1     = 6'h29;
    localparam logic [5:0] R1CFG_PAGE_NV2     = 6'h2A;

    // ==============================================================
    // Field positions
    localparam int R1CFG_SO_MODE_BIT    = 15;
    localparam int R1CFG_SS_MODE_BIT    = 14;
    localparam int R1CFG_SS_DIV_LSB     = 12;
    localparam int R1CFG_SLOW_DIV_LSB   = 10;
    localparam int R1CFG_FAST_LSB       = 0;
    localparam int R1CFG_ICC_LSB        = 0;
    localparam int R1CFG_ICC_ADD_LSB    = 8;
    localparam int R1CFG_PIN_SCALE_LSB  = 13;
    localparam int R1CFG_POUT_SCALE_LSB = 10;
    localparam int R1CFG_AMP_SCALE_LSB  = 8;
    localparam int R1CFG_OVCLK_BIT      = 15;
    localparam int R1CFG_PARID_BIT      = 14;
    localparam int R1CFG_OVERRIDE_BIT   = 13;
    localparam int R1CFG_LL_FINE_LSB    = 6;
    localparam int R1CFG_LL_COARSE_LSB  = 0;
    localparam int R1CFG_PHS_STEP_LSB   = 14;
    localparam int R1CFG_PHS_OFS_LSB    = 9;
    localparam int R1CFG_TOT_OFS_LSB    = 0;
    localparam int R1CFG_TELEM_SRC_LSB  = 14;
    localparam int R1CFG_PSYS_ADDR_LSB  = 10;
    localparam int R1CFG_R2_ADDR_EN_BIT = 9;
    localparam int R1CFG_R1_ADDR_EN_BIT = 8;
    localparam int R1CFG_R2_ADDR_LSB    = 4;
    localparam int R1CFG_R1_ADDR_LSB    = 0;

    // ==============================================================
    // Reset values
    localparam logic [5:0]  R1CFG_RST_PAGE    = 6'h00;
    localparam logic [15:0] R1CFG_RST_SLEW    = 16'h0000;
    localparam logic [15:0] R1CFG_RST_ICCMAX  = 16'h0000;
    localparam logic [15:0] R1CFG_RST_VIDMODE = 16'h0000;
    localparam logic [15:0] R1CFG_RST_IOFFSET = 16'h0000;
    localparam logic [15:0] R1CFG_RST_BUSADDR = 16'h0000;

    // ==============================================================
    // Scaling constants and telemetry source codes
    localparam logic [6:0] R1CFG_LL_COARSE_MULT = 7'h64;
    localparam logic [1:0] R1CFG_ICC_ADD_STEP   = 2'h2;
    localparam logic [1:0] R1CFG_TELEM_RAIL1    = 2'h1;
    localparam logic [1:0] R1CFG_TELEM_RAIL2    = 2'h2;
    localparam logic [1:0] R1CFG_TELEM_SUM      = 2'h3;

endpackage

// ===== src/r1cfg_page_regs.sv
// Rail 1 configuration page: page selector, register bank and derived settings
//
// Operation
// - Page code 00, 01, 02 selects operating page 0, 1, 2.
// - Codes 28, 29, 2A select mirror copies; other codes change nothing.
// - Mirror pages reachable only while the mirror access enable is set.
// - Reserved bits ignore writes and read zero.
// - Bits 15/14 pick soft-off/soft-on rate: divided rate or boot rate.
// - Soft ramp rate is slow rate divided by 1, 2, 4 or 8.
// - Slow rate is fast rate divided by 2, 4, 8 or 16.
// - Ten-bit fast rate field, 0.1 mV/us per step.
// - Eight-bit max current; zero forbids rail start-up.
// - Legacy variant adds bits 15:8 at 2 A per step.
// - Input power scale 2 W doubling up to 256 W per step.
// - Output power scale 1 to 8 W; codes above 3 unsupported.
// - Current scale 1 to 8 A per step for max current.
// - Overclock bit takes target from PMBus; bus commands still answered.
// - Bit 14 enables parallel voltage-ID mode.
// - Bit 13 enables PMBus override mode.
// - Load line is coarse times 0.1 plus fine times 0.001 milliohm.
// - Signed per-phase offset scaled by phase count, added to sensed current.
// - Per-phase step is 0.25, 0.5, 1 or 2 converter steps.
// - Signed total offset, 1 A per step, PMBus readback only.
// - Input telemetry: rail 1, rail 2 or their sum; source code 0 reports zero.
// - Bits 13:10 hold the system power rail bus address.
// - Rail 2 bus address enable bit turns that address on or off.
`timescale 1ns/1ps
module r1cfg_page_regs
    import r1cfg_pkg::*;
#(
    parameter bit LEGACY_VARIANT = 1'b0
)
(
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire logic               cmd_valid,
    input  wire logic               cmd_write,
    input  wire logic        [7:0]  cmd_code,
    input  wire logic        [15:0] cmd_wdata,
    output logic                    rsp_valid,
    output logic                    rsp_hit,
    output logic             [15:0] rsp_rdata,
    input  wire logic               nv_mirror_access_enable,
    input  wire logic        [9:0]  boot_ramp_rate,
    input  wire logic signed [15:0] sensed_current,
    input  wire logic        [3:0]  active_phases,
    input  wire logic        [15:0] rail1_iin,
    input  wire logic        [15:0] rail2_iin,
    input  wire logic        [15:0] rail1_pin,
    input  wire logic        [15:0] rail2_pin,
    output logic             [2:0]  route_oper_page,
    output logic             [2:0]  route_nv_page,
    output logic             [9:0]  fast_ramp_rate,
    output logic             [9:0]  slow_ramp_rate,
    output logic             [9:0]  soft_ramp_rate,
    output logic             [9:0]  soft_on_rate,
    output logic             [9:0]  soft_off_rate,
    output logic                    rail_start_permit,
    output logic             [10:0] reported_max_current,
    output logic             [8:0]  pin_w_per_step,
    output logic             [3:0]  pout_w_per_step,
    output logic                    pout_scale_unsupported,
    output logic             [3:0]  amps_per_step,
    output logic                    overclock_target_enable,
    output logic                    parallel_id_enable,
    output logic                    pmbus_override_enable,
    output logic             [12:0] loadline_micro_ohm,
    output logic signed      [15:0] iout_bus_report,
    output logic signed      [15:0] iout_pmbus_report,
    output logic             [16:0] input_current_report,
    output logic             [16:0] input_power_report,
    output logic             [3:0]  psys_bus_address,
    output logic             [3:0]  rail1_bus_address,
    output logic             [3:0]  rail2_bus_address,
    output logic                    rail1_bus_address_enable,
    output logic                    rail2_bus_address_enable
);

    // ==============================================================
    // Page decoding
    function automatic logic page_is_oper(input logic [5:0] code);
        return (code == R1CFG_PAGE_OP0) || (code == R1CFG_PAGE_OP1)
            || (code == R1CFG_PAGE_OP2);
    endfunction

    function automatic logic page_is_mirror(input logic [5:0] code);
        return (code == R1CFG_PAGE_NV0) || (code == R1CFG_PAGE_NV1)
            || (code == R1CFG_PAGE_NV2);
    endfunction

    logic [5:0]  page_ff;
    logic [15:0] slew_ff;
    logic [15:0] iccmax_ff;
    logic [15:0] vidmode_ff;
    logic [15:0] ioffset_ff;
    logic [15:0] busaddr_ff;

    logic        wr_en;
    logic        rd_en;
    logic        on_this_page;
    logic        page_wr_ok;

    assign wr_en        = cmd_valid && cmd_write;
    assign rd_en        = cmd_valid && !cmd_write;
    // Bank registers answer only while operating page 2 is current
    assign on_this_page = (page_ff == R1CFG_PAGE_OP2);

    assign page_wr_ok = page_is_oper(cmd_wdata[5:0])
        || (page_is_mirror(cmd_wdata[5:0]) && nv_mirror_access_enable);

    // ==============================================================
    // Page selector
    // page write
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            page_ff <= R1CFG_RST_PAGE;
        end else if (wr_en && cmd_code == R1CFG_OFS_PAGE && page_wr_ok) begin
            page_ff <= cmd_wdata[5:0];
        end
    end

    // mirror route dropped when access is withdrawn
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            route_oper_page <= 3'h0;
            route_nv_page   <= 3'h0;
        end else begin
            route_oper_page <= {page_ff == R1CFG_PAGE_OP2, page_ff == R1CFG_PAGE_OP1,
                                page_ff == R1CFG_PAGE_OP0};
            route_nv_page   <= {page_ff == R1CFG_PAGE_NV2, page_ff == R1CFG_PAGE_NV1,
                                page_ff == R1CFG_PAGE_NV0}
                               & {3{nv_mirror_access_enable}};
        end
    end

    // ==============================================================
    // Register bank
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            slew_ff    <= R1CFG_RST_SLEW;
            iccmax_ff  <= R1CFG_RST_ICCMAX;
            vidmode_ff <= R1CFG_RST_VIDMODE;
            ioffset_ff <= R1CFG_RST_IOFFSET;
            busaddr_ff <= R1CFG_RST_BUSADDR;
        end else if (wr_en && on_this_page) begin
            unique case (cmd_code)
                R1CFG_OFS_SLEW:    slew_ff    <= cmd_wdata;
                R1CFG_OFS_ICCMAX:  iccmax_ff  <= cmd_wdata;
                R1CFG_OFS_VIDMODE: vidmode_ff <= cmd_wdata;
                R1CFG_OFS_IOFFSET: ioffset_ff <= cmd_wdata;
                R1CFG_OFS_BUSADDR: busaddr_ff <= cmd_wdata;
                default: begin
                end
            endcase
        end
    end

    // ==============================================================
    // Command answer, one cycle after the command
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_hit   <= 1'b0;
            rsp_rdata <= 16'h0000;
        end else begin
            rsp_valid <= cmd_valid;
            rsp_hit   <= 1'b0;
            rsp_rdata <= 16'h0000;
            if (cmd_valid && cmd_code == R1CFG_OFS_PAGE) begin
                // Refused page codes still count as handled; the page just stays
                rsp_hit <= 1'b1;
                if (rd_en) begin
                    rsp_rdata <= {10'h000, page_ff};
                end
            end else if (cmd_valid && on_this_page) begin
                rsp_hit <= (cmd_code >= R1CFG_OFS_SLEW) && (cmd_code <= R1CFG_OFS_BUSADDR);
                if (rd_en) begin
                    unique case (cmd_code)
                        R1CFG_OFS_SLEW:    rsp_rdata <= slew_ff;
                        R1CFG_OFS_ICCMAX:  rsp_rdata <= iccmax_ff;
                        R1CFG_OFS_VIDMODE: rsp_rdata <= vidmode_ff;
                        R1CFG_OFS_IOFFSET: rsp_rdata <= ioffset_ff;
                        R1CFG_OFS_BUSADDR: rsp_rdata <= busaddr_ff;
                        default:           rsp_rdata <= 16'h0000;
                    endcase
                end
            end
        end
    end

    // ==============================================================
    // Ramp rates
    logic [9:0] fast_c;
    logic [9:0] slow_c;
    logic [9:0] soft_c;
    logic [9:0] son_c;
    logic [9:0] soff_c;

    r1cfg_ramp_calc u_ramp (
        .slew_cfg       (slew_ff),
        .boot_ramp_rate (boot_ramp_rate),
        .fast_ramp_rate (fast_c),
        .slow_ramp_rate (slow_c),
        .soft_ramp_rate (soft_c),
        .soft_on_rate   (son_c),
        .soft_off_rate  (soff_c)
    );

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_ramp_rate <= 10'h000;
            slow_ramp_rate <= 10'h000;
            soft_ramp_rate <= 10'h000;
            soft_on_rate   <= 10'h000;
            soft_off_rate  <= 10'h000;
        end else begin
            fast_ramp_rate <= fast_c;
            slow_ramp_rate <= slow_c;
            soft_ramp_rate <= soft_c;
            soft_on_rate   <= son_c;
            soft_off_rate  <= soff_c;
        end
    end

    // ==============================================================
    // Current limit and power scaling
    logic [7:0]  icc_base;
    logic [10:0] icc_report_c;

    assign icc_base = iccmax_ff[R1CFG_ICC_LSB +: 8];

    always_comb begin
        if (LEGACY_VARIANT) begin
            icc_report_c = {3'h0, icc_base}
                + 11'({iccmax_ff[R1CFG_ICC_ADD_LSB +: 8], 1'b0} * R1CFG_ICC_ADD_STEP / 2);
        end else begin
            icc_report_c = {3'h0, icc_base} << iccmax_ff[R1CFG_AMP_SCALE_LSB +: 2];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rail_start_permit      <= 1'b0;
            reported_max_current   <= 11'h000;
            pin_w_per_step         <= 9'h000;
            pout_w_per_step        <= 4'h0;
            pout_scale_unsupported <= 1'b0;
            amps_per_step          <= 4'h0;
        end else begin
            rail_start_permit    <= (icc_base != 8'h00);
            reported_max_current <= icc_report_c;
            pin_w_per_step       <= 9'h002 << iccmax_ff[R1CFG_PIN_SCALE_LSB +: 3];
            pout_w_per_step        <= 4'h1 << iccmax_ff[R1CFG_POUT_SCALE_LSB +: 2];
            pout_scale_unsupported <= iccmax_ff[R1CFG_POUT_SCALE_LSB + 2];
            amps_per_step          <= 4'h1 << iccmax_ff[R1CFG_AMP_SCALE_LSB +: 2];
        end
    end

    // ==============================================================
    // Control mode and load line
    // Overclock only moves the target source; bus command handling is elsewhere
    // and keeps acknowledging regardless.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            overclock_target_enable <= 1'b0;
            parallel_id_enable      <= 1'b0;
            pmbus_override_enable   <= 1'b0;
            loadline_micro_ohm      <= 13'h0000;
        end else begin
            overclock_target_enable <= vidmode_ff[R1CFG_OVCLK_BIT];
            parallel_id_enable      <= vidmode_ff[R1CFG_PARID_BIT];
            pmbus_override_enable   <= vidmode_ff[R1CFG_OVERRIDE_BIT];
            loadline_micro_ohm <= 13'(vidmode_ff[R1CFG_LL_COARSE_LSB +: 6] * R1CFG_LL_COARSE_MULT)
                                + {6'h00, vidmode_ff[R1CFG_LL_FINE_LSB +: 7]};
        end
    end

    // ==============================================================
    // Report offsets and telemetry
    logic signed [15:0] bus_rpt_c;
    logic signed [15:0] pmbus_rpt_c;
    logic        [16:0] iin_c;
    logic        [16:0] pin_c;

    r1cfg_report_calc u_report (
        .ofs_cfg              (ioffset_ff),
        .telem_src            (busaddr_ff[R1CFG_TELEM_SRC_LSB +: 2]),
        .sensed_current       (sensed_current),
        .active_phases        (active_phases),
        .rail1_iin            (rail1_iin),
        .rail2_iin            (rail2_iin),
        .rail1_pin            (rail1_pin),
        .rail2_pin            (rail2_pin),
        .iout_bus_report      (bus_rpt_c),
        .iout_pmbus_report    (pmbus_rpt_c),
        .input_current_report (iin_c),
        .input_power_report   (pin_c)
    );

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            iout_bus_report      <= 16'sh0000;
            iout_pmbus_report    <= 16'sh0000;
            input_current_report <= 17'h00000;
            input_power_report   <= 17'h00000;
        end else begin
            iout_bus_report      <= bus_rpt_c;
            iout_pmbus_report    <= pmbus_rpt_c;
            input_current_report <= iin_c;
            input_power_report   <= pin_c;
        end
    end

    // ==============================================================
    // Bus addresses
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            psys_bus_address         <= 4'h0;
            rail1_bus_address        <= 4'h0;
            rail2_bus_address        <= 4'h0;
            rail1_bus_address_enable <= 1'b0;
            rail2_bus_address_enable <= 1'b0;
        end else begin
            psys_bus_address         <= busaddr_ff[R1CFG_PSYS_ADDR_LSB +: 4];
            rail1_bus_address        <= busaddr_ff[R1CFG_R1_ADDR_LSB +: 4];
            rail2_bus_address        <= busaddr_ff[R1CFG_R2_ADDR_LSB +: 4];
            rail1_bus_address_enable <= busaddr_ff[R1CFG_R1_ADDR_EN_BIT];
            rail2_bus_address_enable <= busaddr_ff[R1CFG_R2_ADDR_EN_BIT];
        end
    end

endmodule

// ===== src/r1cfg_ramp_calc.sv
// Ramp rate derivation for rail 1 from the slew configuration word
`timescale 1ns/1ps
module r1cfg_ramp_calc
    import r1cfg_pkg::*;
(
    input  wire logic [15:0] slew_cfg,
    input  wire logic [9:0]  boot_ramp_rate,
    output logic      [9:0]  fast_ramp_rate,
    output logic      [9:0]  slow_ramp_rate,
    output logic      [9:0]  soft_ramp_rate,
    output logic      [9:0]  soft_on_rate,
    output logic      [9:0]  soft_off_rate
);

    logic [1:0] slow_div;
    logic [1:0] soft_ramp_divider;

    assign slow_div          = slew_cfg[R1CFG_SLOW_DIV_LSB +: 2];
    assign soft_ramp_divider = slew_cfg[R1CFG_SS_DIV_LSB +: 2];

    assign fast_ramp_rate = slew_cfg[R1CFG_FAST_LSB +: 10];
    assign slow_ramp_rate = fast_ramp_rate >> ({1'b0, slow_div} + 3'h1);
    assign soft_ramp_rate = slow_ramp_rate >> soft_ramp_divider;
    assign soft_on_rate  = slew_cfg[R1CFG_SS_MODE_BIT] ? boot_ramp_rate : soft_ramp_rate;
    assign soft_off_rate = slew_cfg[R1CFG_SO_MODE_BIT] ? boot_ramp_rate : soft_ramp_rate;

endmodule

// ===== src/r1cfg_report_calc.sv
// Current report offsets and input telemetry selection
`timescale 1ns/1ps
module r1cfg_report_calc
    import r1cfg_pkg::*;
(
    input  wire logic        [15:0] ofs_cfg,
    input  wire logic        [1:0]  telem_src,
    input  wire logic signed [15:0] sensed_current,
    input  wire logic        [3:0]  active_phases,
    input  wire logic        [15:0] rail1_iin,
    input  wire logic        [15:0] rail2_iin,
    input  wire logic        [15:0] rail1_pin,
    input  wire logic        [15:0] rail2_pin,
    output logic signed      [15:0] iout_bus_report,
    output logic signed      [15:0] iout_pmbus_report,
    output logic             [16:0] input_current_report,
    output logic             [16:0] input_power_report
);

    logic signed [15:0] phase_ofs;
    logic signed [15:0] step_quarters;
    logic signed [15:0] phase_count;
    logic signed [15:0] adj_quarters;
    logic signed [15:0] total_ofs;

    assign step_quarters = 16'sh0001 <<< ofs_cfg[R1CFG_PHS_STEP_LSB +: 2];
    assign phase_ofs     = 16'(signed'(ofs_cfg[R1CFG_PHS_OFS_LSB +: 5]));
    assign phase_count   = signed'({12'h000, active_phases});
    assign adj_quarters  = 16'(phase_ofs * step_quarters * phase_count);
    assign iout_bus_report = sensed_current + (adj_quarters >>> 2);

    // total offset only on PMBus readback
    assign total_ofs         = 16'(signed'(ofs_cfg[R1CFG_TOT_OFS_LSB +: 9]));
    assign iout_pmbus_report = iout_bus_report + total_ofs;

    always_comb begin
        unique case (telem_src)
            R1CFG_TELEM_RAIL1: begin
                input_current_report = {1'b0, rail1_iin};
                input_power_report   = {1'b0, rail1_pin};
            end
            R1CFG_TELEM_RAIL2: begin
                input_current_report = {1'b0, rail2_iin};
                input_power_report   = {1'b0, rail2_pin};
            end
            R1CFG_TELEM_SUM: begin
                input_current_report = {1'b0, rail1_iin} + {1'b0, rail2_iin};
                input_power_report   = {1'b0, rail1_pin} + {1'b0, rail2_pin};
            end
            default: begin
                input_current_report = 17'h00000;
                input_power_report   = 17'h00000;
            end
        endcase
    end

endmodule

// ===== test/r1cfg_host_model.sv
// Host model issuing one-cycle commands to the configuration page
`timescale 1ns/1ps
module r1cfg_host_model (
    input  wire logic        core_clk,
    output logic             cmd_valid = 1'b0,
    output logic             cmd_write = 1'b0,
    output logic      [7:0]  cmd_code  = 8'h00,
    output logic      [15:0] cmd_wdata = 16'h0000
);
    // ==========================================
    // Command strobe
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_code  <= c;
        cmd_wdata <= d;
        @(posedge core_clk);
        // Released code and data lines flip so stale data never passes for a match
        cmd_valid <= 1'b0;
        cmd_code  <= ~c;
        cmd_wdata <= ~d;
    endtask
endmodule

// ===== test/r1cfg_page_regs_chk.sv
// Port checker for the configuration page
`timescale 1ns/1ps
module r1cfg_page_regs_chk (
    input wire logic        core_clk, rst_n, cmd_valid, cmd_write,
    input wire logic        rsp_valid, rsp_hit, nv_mirror_access_enable,
    input wire logic [7:0]  cmd_code,
    input wire logic [15:0] rsp_rdata,
    input wire logic [2:0]  route_oper_page, route_nv_page,
    input wire logic [9:0]  fast_ramp_rate, slow_ramp_rate, soft_ramp_rate,
    input wire logic [8:0]  pin_w_per_step
);
    // ==========================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_page_ack; cmd_valid && cmd_code == 8'h00 |=> rsp_valid && rsp_hit; endproperty
    a_page_ack: assert property (p_page_ack) else $error("page command unanswered");
    property p_route; $onehot0(route_nv_page) && $onehot0(route_oper_page); endproperty
    a_route: assert property (p_route) else $error("page route not one-hot");
    property p_nv_gate; !nv_mirror_access_enable |=> route_nv_page == 3'h0; endproperty
    a_nv_gate: assert property (p_nv_gate) else $error("mirror page open");
    property p_miss; rsp_valid && !rsp_hit |-> rsp_rdata == 16'h0000; endproperty
    a_miss: assert property (p_miss) else $error("miss returned data");
    property p_page_rd; cmd_valid && !cmd_write && cmd_code == 8'h00 |=> rsp_rdata[15:6] == 10'h0;
    endproperty
    a_page_rd: assert property (p_page_rd) else $error("page high bits set");
    property p_soft; soft_ramp_rate <= slow_ramp_rate; endproperty
    a_soft: assert property (p_soft) else $error("soft rate above slow");
    property p_slow; slow_ramp_rate <= (fast_ramp_rate >> 1); endproperty
    a_slow: assert property (p_slow) else $error("slow rate too high");
    property p_pin; pin_w_per_step != 9'h000 |-> $onehot(pin_w_per_step) && !pin_w_per_step[0];
    endproperty
    a_pin: assert property (p_pin) else $error("input power step bad");
endmodule
bind r1cfg_page_regs r1cfg_page_regs_chk u_chk (.core_clk, .rst_n, .cmd_valid, .cmd_write,
    .rsp_valid, .rsp_hit, .nv_mirror_access_enable, .cmd_code, .rsp_rdata, .route_oper_page,
    .route_nv_page, .fast_ramp_rate, .slow_ramp_rate, .soft_ramp_rate, .pin_w_per_step);

// ===== test/r1cfg_page_regs_tb.sv
// Self-checking bench for the configuration page
`timescale 1ns/1ps
module r1cfg_page_regs_tb;
    import r1cfg_pkg::*;
    logic core_clk = 0, rst_n = 0, nv_mirror_access_enable = 0, cmd_valid, cmd_write, rsp_valid;
    logic rsp_hit, rail_start_permit, pout_scale_unsupported, overclock_target_enable;
    logic parallel_id_enable, pmbus_override_enable, rail1_bus_address_enable;
    logic rail2_bus_address_enable;
    logic [2:0] route_oper_page, route_nv_page;
    logic [3:0] active_phases = 4'h3, pout_w_per_step, amps_per_step, psys_bus_address;
    logic [3:0] rail1_bus_address, rail2_bus_address;
    logic [7:0] cmd_code;
    logic [8:0] pin_w_per_step;
    logic [9:0] boot_ramp_rate = 10'h155, fast_ramp_rate, slow_ramp_rate, soft_ramp_rate;
    logic [9:0] soft_on_rate, soft_off_rate;
    logic [10:0] reported_max_current;
    logic [12:0] loadline_micro_ohm;
    logic [15:0] cmd_wdata, rsp_rdata, rail1_iin = 0, rail2_iin = 0, rail1_pin = 0, rail2_pin = 0;
    logic signed [15:0] sensed_current = 0, iout_bus_report, iout_pmbus_report;
    logic [16:0] input_current_report, input_power_report, q[$];
    logic [15:0] w [1:5];
    int n_errors = 0, samples_checked = 0;
    r1cfg_page_regs DUT (.*);
    r1cfg_host_model HOST (.*);
    // ==========================================
    // Clock, checks and closing
    initial forever #2 core_clk = ~core_clk;
    initial begin #40000; n_errors++; tally_and_finish; end
    always @(negedge core_clk) if (rsp_valid === 1'b1)
        cmp_rsp({rsp_hit, rsp_rdata}, q.pop_front());
    task automatic cmp_lvl(input logic [16:0] g, e);
        samples_checked++;
        if (g !== e) begin n_errors++; $display("wrong value %0t got %h exp %h", $time, g, e); end
    endtask
    task automatic cmp_rsp(input logic [16:0] g, e); cmp_lvl(g, e); endtask
    task automatic cmd(input logic wr, logic [7:0] c, logic [15:0] d, logic [16:0] e);
        q.push_back(e);
        HOST.xfer(wr, c, d);
    endtask
    task automatic settle; repeat (2) @(posedge core_clk); #1; endtask
    function automatic logic [16:0] sel(input logic [15:0] a, b);
        return w[5][15] ? (w[5][14] ? 17'(a) + b : {1'b0, b}) : (w[5][14] ? {1'b0, a} : 17'h0);
    endfunction
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk_derived;
        logic [9:0] s;
        int p;
        s = w[1][9:0] >> (w[1][11:10] + 1);
        p = $signed(w[4][13:9]) * (1 << w[4][15:14]) * int'(active_phases);
        p = sensed_current + (p >>> 2);
        cmp_lvl(fast_ramp_rate, w[1][9:0]);
        cmp_lvl(slow_ramp_rate, s);
        cmp_lvl(soft_ramp_rate, s >> w[1][13:12]);
        cmp_lvl(soft_on_rate, w[1][14] ? boot_ramp_rate : s >> w[1][13:12]);
        cmp_lvl(soft_off_rate, w[1][15] ? boot_ramp_rate : s >> w[1][13:12]);
        cmp_lvl(reported_max_current, 11'(w[2][7:0]) << w[2][9:8]);
        cmp_lvl({rail_start_permit, amps_per_step}, {w[2][7:0] != 0, 4'(1 << w[2][9:8])});
        cmp_lvl(pin_w_per_step, 9'(2 << w[2][15:13]));
        cmp_lvl({pout_scale_unsupported, pout_w_per_step},
            {w[2][12], 4'(1 << w[2][11:10])});
        cmp_lvl({overclock_target_enable, parallel_id_enable, pmbus_override_enable},
            w[3][15:13]);
        cmp_lvl(loadline_micro_ohm, 13'(w[3][5:0] * 100 + w[3][12:6]));
        cmp_lvl({iout_bus_report}, {16'(p)});
        cmp_lvl({iout_pmbus_report}, {16'(p + $signed(w[4][8:0]))});
        cmp_lvl(input_current_report, sel(rail1_iin, rail2_iin));
        cmp_lvl(input_power_report, sel(rail1_pin, rail2_pin));
        cmp_lvl({psys_bus_address, rail2_bus_address_enable, rail1_bus_address_enable,
            rail2_bus_address, rail1_bus_address}, w[5][13:0]);
    endtask
    initial begin
        void'($urandom(58));
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        cmd(1, 8'h00, 16'h00C2, 17'h10000);
        cmd(0, 8'h00, 16'h0000, 17'h10002);
        for (int c = 1; c < 7; c++) cmd(0, c[7:0], 16'h0000, {c < 6, 16'h0000});
        cmd(1, 8'h00, 16'h003F, 17'h10000);
        cmd(1, 8'h00, 16'h0028, 17'h10000);
        cmd(0, 8'h00, 16'h0000, 17'h10002);
        nv_mirror_access_enable <= 1'b1;
        cmd(1, 8'h00, 16'h0029, 17'h10000);
        cmd(0, 8'h00, 16'h0000, 17'h10029);
        cmd(0, 8'h01, 16'h0000, 17'h00000);
        settle;
        cmp_lvl(route_nv_page, 3'b010);
        nv_mirror_access_enable <= 1'b0;
        cmd(1, 8'h00, 16'h0002, 17'h10000);
        settle;
        cmp_lvl({route_nv_page, route_oper_page}, 6'b000100);
        for (int it = 0; it < 4; it++) begin
            {rail1_iin, rail2_iin} <= $urandom;
            {rail1_pin, rail2_pin} <= $urandom;
            {sensed_current, boot_ramp_rate, active_phases} <= 30'($urandom);
            for (int r = 1; r < 6; r++) w[r] = 16'($urandom);
            w[5][15:14] = it[1:0];
            if (it == 0) w[2][7:0] = 8'h00;
            for (int r = 1; r < 6; r++) begin
                cmd(1, r[7:0], w[r], 17'h10000);
                cmd(0, r[7:0], 16'h0000, {1'b1, w[r]});
            end
            settle;
            chk_derived;
        end
        tally_and_finish;
    end
endmodule
